// file: logic/crwl_pkg.sv
// crwl_pkg: constants and carrier types of the config write-lock block
// assumes a 32-bit classic Wishbone slave and mclk at 100 MHz
package crwl_pkg;
   localparam int DATA_W  = 32;
   localparam int ADR_W   = 8;
   localparam int IDX_W   = 6;
   localparam int MAX_CFG = 8;

   // word indices, byte address = index * 4
   localparam logic [IDX_W-1:0] IDX_SOFTRST  = 6'h00;
   localparam logic [IDX_W-1:0] IDX_LOCKSTAT = 6'h01;
   localparam logic [IDX_W-1:0] IDX_FLDLOCK  = 6'h02;
   localparam logic [IDX_W-1:0] IDX_CPUSTAT  = 6'h03;
   localparam logic [IDX_W-1:0] IDX_IRQSTAT  = 6'h04;
   localparam logic [IDX_W-1:0] IDX_IRQMASK  = 6'h05;
   localparam logic [IDX_W-1:0] IDX_CFG_BASE = 6'h10;

   // lock bit encoding and field positions
   localparam logic LOCK_OPEN    = 1'b1;
   localparam logic SR_HOLD      = 1'b1;
   localparam int   LOCK_CFG_POS = 8;

   // reset values
   localparam logic [DATA_W-1:0] CFG_RST_VAL = 32'h0000_0000;
   localparam logic [DATA_W-1:0] WORD_ZERO   = 32'h0000_0000;

   // interrupt events, bit 0 is lockedWr
   typedef struct packed {
      logic initDone;
      logic cpuRun;
      logic lockedWr;
   } crwl_irq_t;
   localparam int IRQ_W = $bits(crwl_irq_t);

   // processor status word, bit 0 is cpuInReset
   typedef struct packed {
      logic jtagVis;
      logic disableFuse;
      logic permitFuse;
      logic initDone;
      logic cpuInReset;
   } crwl_cpu_st_t;
endpackage

// file: logic/crwl_lock_reg.sv
// crwl_lock_reg: one register guarded by a whole lock and field locks
// assumes write strobe, data and lane mask arrive from the bus slave
`timescale 1ns/10ps
module crwl_lock_reg
   import crwl_pkg::*;
#(
   parameter int               NF     = 1,
   parameter int               FW     = 32,
   parameter logic [NF*FW-1:0] RSTVAL = '0
)(
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             srst,
   // lock bits, 1 = writable
   input  wire logic             regOpen,
   input  wire logic [NF-1:0]    fieldOpen,
   // nonvolatile preload
   input  wire logic             loadStb,
   input  wire logic [NF*FW-1:0] loadData,
   // bus write
   input  wire logic             wrStb,
   input  wire logic [NF*FW-1:0] wrData,
   input  wire logic [NF*FW-1:0] wrMask,
   // contents and refused write
   output logic      [NF*FW-1:0] q,
   output logic                  blocked
);
   localparam int W = NF * FW;
   if (NF < 1 || FW < 1 || W > DATA_W) begin : g_bad
      $error("crwl_lock_reg: unsupported shape");
   end

   logic [W-1:0] q_reg;
   logic [W-1:0] q_next;
   logic [W-1:0] openMask;
   logic [W-1:0] effMask;

   for (genvar f = 0; f < NF; f++) begin : g_fld
      assign openMask[f*FW +: FW] = {FW{regOpen & fieldOpen[f]}};
   end
   assign effMask = wrMask & openMask;
   assign q_next  = loadStb ? loadData
                  : wrStb   ? (q_reg & ~effMask) | (wrData & effMask)
                  : q_reg;
   // refused write is swallowed, the bus still gets a normal ack
   assign blocked = wrStb & (|(wrMask & ~openMask));
   assign q       = q_reg;

   always_ff @(posedge mclk) begin
      if (srst) begin
         q_reg <= RSTVAL;
      end else begin
         q_reg <= q_next;
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (srst);

   chk_locked_bits: assert property (
      wrStb && !loadStb |=> ((q ^ $past(q)) & ~$past(openMask)) == '0)
      else $error("locked bits changed by a bus write");
   chk_open_write: assert property (
      wrStb && !loadStb |=> ((q ^ $past(wrData)) & $past(effMask)) == '0)
      else $error("writable bits did not take the write");
endmodule

// file: logic/crwl_cpu_reset.sv
// crwl_cpu_reset: processor hold-in-reset and permit fuse visibility
// assumes fuses and flash ties are static levels synchronous to mclk
`timescale 1ns/10ps
module crwl_cpu_reset
   import crwl_pkg::*;
(
   // clock and reset
   input  wire logic   mclk,
   input  wire logic   srst,
   // sequencing
   input  wire logic   initDone,
   // processor controls and fuses
   input  wire logic   cpuResetHoldN,
   input  wire logic   holdTieFlash,
   input  wire logic   cpuPermitFuse,
   input  wire logic   cpuDisableFuse,
   // debug port visibility
   input  wire logic   subsystemResetNFromFabric,
   output logic        jtagPermitValid,
   output logic        jtagPermitFuse,
   // processor reset and status
   output logic        cpuResetN,
   output crwl_cpu_st_t cpuSt
);
   logic holdEff;
   logic runOk;
   logic cpuResetN_reg;
   logic jtagValid_reg;
   logic jtagBit_reg;

   // flash tie overrides the fabric level, immune to upsets
   assign holdEff = holdTieFlash ? 1'b0 : cpuResetHoldN;
   assign runOk   = initDone & holdEff
                  & cpuPermitFuse & ~cpuDisableFuse;

   always_ff @(posedge mclk) begin
      if (srst) begin
         cpuResetN_reg <= 1'b0;
         jtagValid_reg <= 1'b0;
         jtagBit_reg   <= 1'b0;
      end else begin
         cpuResetN_reg <= runOk;
         jtagValid_reg <= subsystemResetNFromFabric;
         jtagBit_reg   <= subsystemResetNFromFabric & cpuPermitFuse;
      end
   end

   assign cpuResetN       = cpuResetN_reg;
   assign jtagPermitValid = jtagValid_reg;
   assign jtagPermitFuse  = jtagBit_reg;
   assign cpuSt = '{jtagVis: jtagValid_reg, disableFuse: cpuDisableFuse,
                    permitFuse: cpuPermitFuse, initDone: initDone,
                    cpuInReset: ~cpuResetN_reg};

   default clocking @(posedge mclk); endclocking
   default disable iff (srst);

   chk_init_hold: assert property (
      !initDone |=> !cpuResetN)
      else $error("processor released during initialization");
   chk_hold_follow: assert property (
      initDone && cpuPermitFuse && !cpuDisableFuse && !holdTieFlash
      |=> cpuResetN == $past(cpuResetHoldN))
      else $error("processor reset does not follow hold input");
   chk_flash_tie: assert property (
      holdTieFlash [*2] |-> !cpuResetN)
      else $error("processor released while tied by flash");
   chk_fuse_kill: assert property (
      !cpuPermitFuse || cpuDisableFuse |=> !cpuResetN)
      else $error("processor released on a part not permitted");
   chk_jtag_gate: assert property (
      !subsystemResetNFromFabric |=> !jtagPermitValid && !jtagPermitFuse)
      else $error("permit fuse visible while subsystem in reset");
endmodule

// file: logic/crwl_top.sv
// crwl_top: lockable configuration and soft reset registers on Wishbone
// assumes flash lock bits and preload values are valid once nvValid rises
//
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
module crwl_top
   import crwl_pkg::*;
#(
   parameter int                NSR     = 27,
   parameter int                NCFG    = 2,
   parameter logic [DATA_W-1:0] CFG_RST = CFG_RST_VAL
)(
   // clock and reset
   input  wire logic                       mclk,
   input  wire logic                       srst,
   // classic Wishbone slave
   input  wire logic                       wb_cyc_i,
   input  wire logic                       wb_stb_i,
   input  wire logic                       wb_we_i,
   input  wire logic [ADR_W-1:0]           wb_adr_i,
   input  wire logic [3:0]                 wb_sel_i,
   input  wire logic [DATA_W-1:0]          wb_dat_i,
   output logic      [DATA_W-1:0]          wb_dat_o,
   output logic                            wb_ack_o,
   // nonvolatile lock bits and preload
   input  wire logic                       nvValid,
   input  wire logic                       nvSoftRegOpen,
   input  wire logic [NSR-1:0]             nvSoftFieldOpen,
   input  wire logic [NCFG-1:0]            nvCfgOpen,
   input  wire logic [NSR-1:0]             nvSoftRstInit,
   // processor controls and fuses
   input  wire logic                       cpuResetHoldN,
   input  wire logic                       holdTieFlash,
   input  wire logic                       cpuPermitFuse,
   input  wire logic                       cpuDisableFuse,
   input  wire logic                       subsystemResetNFromFabric,
   // processor reset and debug visibility
   output logic                            cpuResetN,
   output logic                            jtagPermitValid,
   output logic                            jtagPermitFuse,
   // sub-block resets and configuration words
   output logic      [NSR-1:0]             subBlockRst,
   output logic      [NCFG-1:0][DATA_W-1:0] cfgOut,
   // interrupt
   output logic                            irq
);
   localparam int W  = DATA_W;
   localparam int CW = (NCFG > 1) ? $clog2(NCFG) : 1;

   if (NSR < 1 || NSR > DATA_W) begin : g_bad_nsr
      $error("crwl_top: NSR out of range");
   end
   if (NCFG < 1 || NCFG > MAX_CFG || NCFG > W - LOCK_CFG_POS)
   begin : g_bad_ncfg
      $error("crwl_top: NCFG out of range");
   end

   ////////////////////////////////////////////////////////////////////////
   // bus slave: ack one cycle after the request, write on the ack edge
   logic             ack_reg;
   logic             ack_next;
   logic [W-1:0]     rdData_reg;
   logic [W-1:0]     rdData_next;
   logic             req;
   logic             wrStb;
   logic [IDX_W-1:0] aIdx;
   logic [IDX_W-1:0] cfgSel;
   logic [CW-1:0]    cfgIdx;
   logic [W-1:0]     wrMask;
   logic             hitSr;
   logic             hitLock;
   logic             hitFld;
   logic             hitCpu;
   logic             hitIrqS;
   logic             hitIrqM;
   logic             hitCfg;

   assign req      = wb_cyc_i & wb_stb_i;
   assign ack_next = req & ~ack_reg;
   assign wrStb    = req & wb_we_i & ack_reg;
   assign aIdx     = wb_adr_i[ADR_W-1:2];
   assign wrMask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                      {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   assign hitSr   = aIdx == IDX_SOFTRST;
   assign hitLock = aIdx == IDX_LOCKSTAT;
   assign hitFld  = aIdx == IDX_FLDLOCK;
   assign hitCpu  = aIdx == IDX_CPUSTAT;
   assign hitIrqS = aIdx == IDX_IRQSTAT;
   assign hitIrqM = aIdx == IDX_IRQMASK;
   assign cfgSel  = aIdx - IDX_CFG_BASE;
   assign cfgIdx  = cfgSel[CW-1:0];
   assign hitCfg  = (aIdx >= IDX_CFG_BASE) && (cfgSel < IDX_W'(NCFG));

   ////////////////////////////////////////////////////////////////////////
   // lock bits and preload, caught once after reset release
   logic            initDone_reg;
   logic            softOpen_reg;
   logic [NSR-1:0]  fieldOpen_reg;
   logic [NCFG-1:0] cfgOpen_reg;
   logic            loadStb;

   assign loadStb = nvValid & ~initDone_reg;

   always_ff @(posedge mclk) begin
      if (srst) begin
         initDone_reg  <= 1'b0;
         softOpen_reg  <= LOCK_OPEN;
         fieldOpen_reg <= {NSR{LOCK_OPEN}};
         cfgOpen_reg   <= {NCFG{LOCK_OPEN}};
      end else if (loadStb) begin
         initDone_reg  <= 1'b1;
         softOpen_reg  <= nvSoftRegOpen;
         fieldOpen_reg <= nvSoftFieldOpen;
         cfgOpen_reg   <= nvCfgOpen;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // soft reset control: whole-register and per-field locks
   logic [NSR-1:0]  softQ;
   logic            srBlocked;

   crwl_lock_reg #(
      .NF     (NSR),
      .FW     (1),
      .RSTVAL ({NSR{SR_HOLD}})
   ) u_softrst (
      .mclk      (mclk),
      .srst      (srst),
      .regOpen   (softOpen_reg),
      .fieldOpen (fieldOpen_reg),
      .loadStb   (loadStb),
      .loadData  (nvSoftRstInit),
      .wrStb     (wrStb & hitSr),
      .wrData    (wb_dat_i[NSR-1:0]),
      .wrMask    (wrMask[NSR-1:0]),
      .q         (softQ),
      .blocked   (srBlocked)
   );

   assign subBlockRst = softQ;

   ////////////////////////////////////////////////////////////////////////
   // configuration registers, each under one register lock
   logic [NCFG-1:0][W-1:0] cfgQ;
   logic [NCFG-1:0]        cfgWr;
   logic [NCFG-1:0]        cfgBlk;

   for (genvar g = 0; g < NCFG; g++) begin : g_cfg
      assign cfgWr[g] = wrStb & hitCfg & (cfgSel == IDX_W'(g));
      crwl_lock_reg #(
         .NF     (1),
         .FW     (W),
         .RSTVAL (CFG_RST)
      ) u_cfg (
         .mclk      (mclk),
         .srst      (srst),
         .regOpen   (cfgOpen_reg[g]),
         .fieldOpen (LOCK_OPEN),
         .loadStb   (1'b0),
         .loadData  (WORD_ZERO),
         .wrStb     (cfgWr[g]),
         .wrData    (wb_dat_i),
         .wrMask    (wrMask),
         .q         (cfgQ[g]),
         .blocked   (cfgBlk[g])
      );
   end

   assign cfgOut = cfgQ;

   ////////////////////////////////////////////////////////////////////////
   // processor reset control
   crwl_cpu_st_t cpuSt;

   crwl_cpu_reset u_cpu (
      .mclk                      (mclk),
      .srst                      (srst),
      .initDone                  (initDone_reg),
      .cpuResetHoldN             (cpuResetHoldN),
      .holdTieFlash              (holdTieFlash),
      .cpuPermitFuse             (cpuPermitFuse),
      .cpuDisableFuse            (cpuDisableFuse),
      .subsystemResetNFromFabric (subsystemResetNFromFabric),
      .jtagPermitValid           (jtagPermitValid),
      .jtagPermitFuse            (jtagPermitFuse),
      .cpuResetN                 (cpuResetN),
      .cpuSt                     (cpuSt)
   );

   ////////////////////////////////////////////////////////////////////////
   // interrupts: sticky events, write one to clear, set wins
   crwl_irq_t        ev;
   logic [IRQ_W-1:0] evVec;
   logic [IRQ_W-1:0] w1c;
   logic [IRQ_W-1:0] mskWr;
   logic [IRQ_W-1:0] irqStat_reg;
   logic [IRQ_W-1:0] irqStat_next;
   logic [IRQ_W-1:0] irqMask_reg;
   logic [IRQ_W-1:0] irqMask_next;
   logic             cpuRunPrev_reg;

   // release of the processor is flagged for the fabric monitor
   assign ev.lockedWr = srBlocked | (|cfgBlk);
   assign ev.cpuRun   = cpuResetN & ~cpuRunPrev_reg;
   assign ev.initDone = loadStb;
   assign evVec       = ev;

   assign w1c   = (wrStb & hitIrqS) ? wb_dat_i[IRQ_W-1:0] & wrMask[IRQ_W-1:0]
                : '0;
   assign mskWr = (wrStb & hitIrqM) ? wrMask[IRQ_W-1:0] : '0;
   assign irqStat_next = (irqStat_reg & ~w1c) | evVec;
   assign irqMask_next = (irqMask_reg & ~mskWr)
                       | (wb_dat_i[IRQ_W-1:0] & mskWr);
   assign irq = |(irqStat_reg & irqMask_reg);

   always_ff @(posedge mclk) begin
      if (srst) begin
         irqStat_reg    <= '0;
         irqMask_reg    <= '0;
         cpuRunPrev_reg <= 1'b0;
      end else begin
         irqStat_reg    <= irqStat_next;
         irqMask_reg    <= irqMask_next;
         cpuRunPrev_reg <= cpuResetN;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read selection, unmapped words read zero and still ack
   logic [W-1:0] rdSr;
   logic [W-1:0] rdLock;
   logic [W-1:0] rdFld;
   logic [W-1:0] rdCpu;
   logic [W-1:0] rdCfg;
   logic [W-1:0] rdMux;

   assign rdSr   = W'(softQ);
   assign rdLock = (W'(cfgOpen_reg) << LOCK_CFG_POS) | W'(softOpen_reg);
   assign rdFld  = W'(fieldOpen_reg);
   assign rdCpu  = W'(cpuSt);
   assign rdCfg  = cfgQ[cfgIdx];
   assign rdMux  = hitSr   ? rdSr
                 : hitLock ? rdLock
                 : hitFld  ? rdFld
                 : hitCpu  ? rdCpu
                 : hitIrqS ? W'(irqStat_reg)
                 : hitIrqM ? W'(irqMask_reg)
                 : hitCfg  ? rdCfg
                 : WORD_ZERO;
   assign rdData_next = (ack_next & ~wb_we_i) ? rdMux : rdData_reg;

   always_ff @(posedge mclk) begin
      if (srst) begin
         ack_reg    <= 1'b0;
         rdData_reg <= WORD_ZERO;
      end else begin
         ack_reg    <= ack_next;
         rdData_reg <= rdData_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdData_reg;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);

   sequence s_newReq;
      req && !ack_reg;
   endsequence
   sequence s_oneAck;
      ack_reg ##1 !ack_reg;
   endsequence
   sequence s_cfgOpenWr;
      req && wb_we_i && hitCfg && cfgOpen_reg[cfgIdx] && (wb_sel_i == 4'hF);
   endsequence

   chk_bus_ack: assert property (
      s_newReq |=> s_oneAck)
      else $error("bus ack missing or longer than one cycle");
   chk_lock_default: assert property (
      !initDone_reg |-> softOpen_reg && (&fieldOpen_reg) && (&cfgOpen_reg))
      else $error("a lock bit is closed before it was programmed");
   chk_powerup_hold: assert property (
      !initDone_reg |-> &subBlockRst)
      else $error("sub-block out of reset before preload");
   chk_disabled_kept: assert property (
      loadStb |=> (subBlockRst & $past(nvSoftRstInit))
                  == $past(nvSoftRstInit))
      else $error("disabled sub-block not held in reset");
   chk_locked_silent: assert property (
      wrStb && hitSr && !softOpen_reg && !loadStb
      |=> subBlockRst == $past(subBlockRst)
          && (irqStat_reg[0] || $past(wrMask[NSR-1:0]) == '0))
      else $error("locked soft reset register changed");
   chk_locked_flag: assert property (
      wrStb && hitCfg && !cfgOpen_reg[cfgIdx] && (wb_sel_i != 4'h0)
      |=> irqStat_reg[0])
      else $error("refused write did not raise its status bit");
   chk_cfg_read: assert property (
      s_newReq ##0 (!wb_we_i && hitCfg) |=> wb_dat_o == $past(rdCfg))
      else $error("configuration read does not show contents");
   chk_set_wins: assert property (
      (|evVec) |=> (irqStat_reg & $past(evVec)) == $past(evVec))
      else $error("event lost against a status clear");

   chk_cfg_write: assert property (
      s_newReq ##0 s_cfgOpenWr ##1 s_cfgOpenWr
      |=> cfgOut[$past(cfgIdx)] == $past(wb_dat_i))
      else $error("open configuration word missed a write");
   chk_read_stands: assert property (
      s_newReq ##0 wb_we_i |=> $stable(wb_dat_o))
      else $error("read data changed on a write");
   chk_mask_write: assert property (
      wrStb && hitIrqM && wb_sel_i[0]
      |=> irqMask_reg == $past(wb_dat_i[IRQ_W-1:0]))
      else $error("interrupt mask did not take the write");
   chk_status_clear: assert property (
      wrStb && hitIrqS && wb_sel_i[0] && !(|evVec)
      |=> (irqStat_reg & $past(wb_dat_i[IRQ_W-1:0])) == '0)
      else $error("status bit not cleared by writing one");
   chk_run_event: assert property (
      $rose(cpuResetN) |=> irqStat_reg[1])
      else $error("processor release not flagged");
   chk_init_event: assert property (
      loadStb |=> initDone_reg && irqStat_reg[2])
      else $error("preload not flagged as init done");
endmodule

// file: tb/crwl_boot_master.sv
// crwl_boot_master: power-up loader of the configuration words
// assumes a classic Wishbone slave; idle outputs are zero for an OR bus
`timescale 1ns/10ps
module crwl_boot_master
   import crwl_pkg::*;
#(
   parameter int                        NW   = 2,
   parameter logic [NW-1:0][DATA_W-1:0] VALS = '0
)(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              srst,
   // start and completion
   input  wire logic              go,
   output logic                   done,
   // Wishbone master, stb follows cyc
   input  wire logic              ack,
   output logic                   cyc,
   output logic                   we,
   output logic      [ADR_W-1:0]  adr,
   output logic      [DATA_W-1:0] dat
);
   int               wordIdx;
   logic [IDX_W-1:0] wIdx;

   assign wIdx = IDX_CFG_BASE + IDX_W'(wordIdx);
   assign we   = cyc;
   assign adr  = cyc ? {wIdx, 2'h0} : '0;
   assign dat  = cyc ? VALS[wordIdx] : '0;

   always_ff @(posedge mclk) begin
      if (srst) begin
         cyc     <= 1'h0;
         done    <= 1'h0;
         wordIdx <= 0;
      end else if (cyc && ack) begin
         // release at the ack edge, low for one cycle after
         cyc     <= 1'h0;
         wordIdx <= wordIdx + 1;
         done    <= (wordIdx + 1 == NW);
      end else if (go && !cyc && !done) begin
         cyc <= 1'h1;
      end
   end
endmodule

// file: tb/testbench.sv
// testbench: random and corner tests of the config write-lock block
// assumes crwl_pkg and crwl_boot_master are compiled before this file
`timescale 1ns/10ps
`define CHK(a, e) begin samplesChecked++; if ((a) !== (e)) begin \
   miscompares++; $display("Error at %0t: got %h expected %h", \
   $time, a, e); end end
module testbench
   import crwl_pkg::*;
;
   localparam int          NSR   = 27;
   localparam logic [31:0] BOOT0 = 32'h5A3C_96E1;

   logic                    mclk    = 1'h0;
   logic                    srst    = 1'h1;
   logic                    tCyc    = 1'h0;
   logic                    tWe     = 1'h0;
   logic                    nvValid = 1'h0;
   logic                    regOpen = 1'h1;
   logic [ADR_W-1:0]        tAdr    = '0;
   logic [3:0]              tSel    = '0;
   logic [DATA_W-1:0]       tDat    = '0;
   logic [31:0]             lf      = 32'hCD61;
   logic [NSR-1:0]          fOpen   = '1;
   logic [NSR-1:0]          sInit   = '1;
   logic [4:0]              cpuIn   = 5'h15;
   logic [31:0]             rd, d, ex;
   logic [NSR-1:0]          sExp, wm, sbr;
   logic                    bCyc, bWe, bDone, ack, irq, cpuResetN, jv, jf;
   logic [ADR_W-1:0]        bAdr;
   logic [DATA_W-1:0]       bDat, datO;
   logic [1:0][DATA_W-1:0]  cfg;
   int                      miscompares    = 0;
   int                      samplesChecked = 0;

   crwl_top #(.NSR(NSR), .NCFG(2), .CFG_RST(CFG_RST_VAL)) u_crwl_top (
      .mclk(mclk), .srst(srst), .wb_cyc_i(tCyc | bCyc),
      .wb_stb_i(tCyc | bCyc), .wb_we_i(tWe | bWe), .wb_adr_i(tAdr | bAdr),
      .wb_sel_i(tSel | {4{bCyc}}), .wb_dat_i(tDat | bDat),
      .wb_dat_o(datO), .wb_ack_o(ack), .nvValid(nvValid),
      .nvSoftRegOpen(regOpen), .nvSoftFieldOpen(fOpen),
      .nvCfgOpen(2'h1), .nvSoftRstInit(sInit),
      .cpuResetHoldN(cpuIn[0]), .holdTieFlash(cpuIn[1]),
      .cpuPermitFuse(cpuIn[2]), .cpuDisableFuse(cpuIn[3]),
      .subsystemResetNFromFabric(cpuIn[4]), .cpuResetN(cpuResetN),
      .jtagPermitValid(jv), .jtagPermitFuse(jf), .subBlockRst(sbr),
      .cfgOut(cfg), .irq(irq));

   crwl_boot_master #(.NW(2), .VALS({CFG_RST_VAL, BOOT0}))
   u_crwl_boot_master (
      .mclk(mclk), .srst(srst), .go(nvValid), .done(bDone), .ack(ack),
      .cyc(bCyc), .we(bWe), .adr(bAdr), .dat(bDat));

   ////////////////////////////////////////////////////////////////////////
   always #5 mclk = ~mclk;

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic rnd(output logic [31:0] v);
      lf = lfsr_next(lf);
      v = lf;
   endtask

   function automatic logic cpu_exp(input logic [4:0] c);
      return c[0] & ~c[1] & c[2] & ~c[3];
   endfunction

   function automatic logic [NSR-1:0] lanes(input logic [3:0] s);
      return NSR'({{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}});
   endfunction

   // one classic cycle; returns half a cycle after the ack edge
   task automatic wb(input logic w, input logic [IDX_W-1:0] idx,
                     input logic [31:0] wd, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge mclk);
      tCyc <= 1'h1;
      tWe  <= w;
      tAdr <= {idx, 2'h0};
      tSel <= s;
      tDat <= wd;
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'h1 && n < 50);
      if (n >= 50)
         miscompares++;
      rd = datO;
      tCyc <= 1'h0;
      tWe  <= 1'h0;
      tSel <= '0;
      tAdr <= '0;
      tDat <= '0;
      @(negedge mclk);
   endtask

   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", samplesChecked, miscompares);
      if (miscompares == 0 && samplesChecked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // watchdog: the run needs well under 3000 cycles
   initial begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      wrap_up();
   end

   initial begin
      for (int p = 0; p < 2; p++) begin
         @(posedge mclk);
         srst    <= 1'h1;
         nvValid <= 1'h0;
         cpuIn   <= 5'h15;
         regOpen <= (p == 0);
         repeat (10) @(posedge mclk);
         srst <= 1'h0;
         @(negedge mclk);
         `CHK(sbr, {NSR{1'h1}})
         wb(1'h0, IDX_LOCKSTAT, '0, 4'hF);
         `CHK(rd, 32'h0000_0301)
         `CHK(cpuResetN, 1'h0)
         rnd(d);
         rnd(ex);
         @(posedge mclk);
         fOpen   <= (d[NSR-1:0] | 27'h1) & ~27'h2;
         sInit   <= ex[NSR-1:0];
         nvValid <= 1'h1;
         sExp = ex[NSR-1:0];
         for (int n = 0; n < 100 && bDone !== 1'h1; n++)
            @(posedge mclk);
         @(negedge mclk);
         `CHK(bDone, 1'h1)
         `CHK(sbr, sExp)
         `CHK(cfg[0], BOOT0)
         `CHK(cpuResetN, 1'h1)
         wb(1'h0, IDX_CPUSTAT, '0, 4'hF);
         `CHK(rd, 32'h0000_0016)
         wb(1'h0, IDX_LOCKSTAT, '0, 4'hF);
         `CHK(rd, {22'h0, 2'h1, 7'h0, regOpen})
         wb(1'h0, IDX_FLDLOCK, '0, 4'hF);
         `CHK(rd, 32'(fOpen))
         for (int i = 0; i < 4; i++) begin
            rnd(d);
            rnd(ex);
            wm = regOpen ? fOpen & lanes(ex[3:0]) : '0;
            sExp = (sExp & ~wm) | (d[NSR-1:0] & wm);
            wb(1'h1, IDX_SOFTRST, d, ex[3:0]);
            `CHK(sbr, sExp)
            wb(1'h0, IDX_SOFTRST, '0, 4'hF);
            `CHK(rd, 32'(sExp))
         end
         rnd(d);
         wb(1'h1, IDX_CFG_BASE + 6'h1, d, 4'hF);
         `CHK(cfg[1], CFG_RST_VAL)
         wb(1'h0, IDX_CFG_BASE + 6'h1, '0, 4'hF);
         `CHK(rd, CFG_RST_VAL)
         wb(1'h1, IDX_CFG_BASE, d, 4'hF);
         `CHK(cfg[0], d)
         wb(1'h0, IDX_IRQSTAT, '0, 4'hF);
         `CHK(rd, 32'h0000_0007)
         `CHK(irq, 1'h0)
         wb(1'h1, IDX_IRQMASK, 32'h0000_0001, 4'hF);
         `CHK(irq, 1'h1)
         wb(1'h1, IDX_IRQSTAT, 32'h0000_0001, 4'hF);
         `CHK(irq, 1'h0)
         wb(1'h0, IDX_IRQSTAT, '0, 4'hF);
         `CHK(rd, 32'h0000_0006)
         wb(1'h0, 6'h3F, '0, 4'hF);
         `CHK(rd, WORD_ZERO)
         for (int k = 0; k < 32; k++) begin
            @(posedge mclk);
            cpuIn <= 5'(k);
            repeat (2) @(posedge mclk);
            @(negedge mclk);
            `CHK(cpuResetN, cpu_exp(cpuIn))
            `CHK(jv, cpuIn[4])
            `CHK(jf, cpuIn[4] & cpuIn[2])
         end
      end
      wrap_up();
   end
endmodule
